// ### include/pwt_params.svh
/*
 * Register map, field positions and reset values of the buffered PWM timer channel.
 * Assumes inclusion by bare name from files that need the constants; definitions only.
 */
`ifndef PWT_PARAMS_SVH
`define PWT_PARAMS_SVH

// Register word indices, byte address = index * 4
`define PWT_IDX_CTRL 4'h0
`define PWT_IDX_STAT 4'h1
`define PWT_IDX_PERIOD 4'h2
`define PWT_IDX_C0R 4'h3
`define PWT_IDX_C0F 4'h4
`define PWT_IDX_C1R 4'h5
`define PWT_IDX_C1F 4'h6
`define PWT_IDX_CONV 4'h7
`define PWT_IDX_IE 4'h8
`define PWT_IDX_IS 4'h9
`define PWT_IDX_ICLR 4'hA
`define PWT_IDX_NONE 4'hF
`define PWT_IDX_LAST 4'hA

// Control register fields
`define PWT_CTRL_START 0
`define PWT_CTRL_STOP 1
`define PWT_CTRL_UPD 2
`define PWT_CTRL_CYC_EN 3
`define PWT_CTRL_SRC_SEL 4
`define PWT_CTRL_CAP_MODE 5
`define PWT_CTRL_FS_EN 6
`define PWT_CTRL_DLY_LSB 8
`define PWT_CTRL_DLY_MSB 15
`define PWT_CTRL_TSTART_EN 16
`define PWT_CTRL_TSTOP_EN 17
`define PWT_CTRL_TCLR_EN 18

// Interrupt source bit positions
`define PWT_IS_PERIOD 0
`define PWT_IS_C0R 1
`define PWT_IS_C0F 2
`define PWT_IS_C1R 3
`define PWT_IS_C1F 4
`define PWT_IS_TSTOP 5
`define PWT_IS_TSTART 6
`define PWT_IS_FSTOP 7

// Reset values
`define PWT_CTRL_RST 32'h0000_0000
`define PWT_SET_RST 16'hFFFF
`define PWT_CMP_RST 16'h0000
`define PWT_IE_RST 8'h00

`endif

// ### include/pwt_pkg.sv
/*
 * Types shared by the buffered PWM timer channel.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pwt_pkg;

   typedef enum logic [1:0] {
      PWT_ST_IDLE  = 2'b00,
      PWT_ST_RUN   = 2'b01,
      PWT_ST_DELAY = 2'b10
   } pwt_state_e;

   typedef logic [15:0] pwt_count_t;

endpackage : pwt_pkg

// ### hw/pwt_sync.sv
/*
 * Two-flop synchroniser for a bundle of asynchronous trigger pins.
 * Assumes each bit is an independent level; no bus coherency is implied.
 */
`timescale 1ns/1ps

module pwt_sync #(
   parameter int W = 5
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : pwt_sync

// ### hw/pwt_timer.sv
/*
 * One PWM timer channel with buffered period/compare update, cycle stop,
 * forced stop, capture and interrupt status/enable/clear, behind an APB slave.
 * Assumes one 100 MHz clock pclk, the counter ticking every pclk, and
 * asynchronous trigger pins that are synchronised here.
 */
`timescale 1ns/1ps
`include "pwt_params.svh"

module pwt_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trig_start_in,
   input wire logic trig_stop_in,
   input wire logic trig_clear_in,
   input wire logic trig_force_in,
   input wire logic capture_in,
   output logic pwm0_out,
   output logic pwm1_out,
   output logic irq
);
   import pwt_pkg::*;

   function automatic logic [3:0] pwt_reg_index(input logic [7:0] addr);
      logic [3:0] idx;
      idx = `PWT_IDX_NONE;
      if (addr[1:0] == 2'h0 && addr[7:2] <= {2'h0, `PWT_IDX_LAST}) begin
         idx = addr[5:2];
      end
      return idx;
   endfunction : pwt_reg_index

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   pwt_state_e state_r;
   logic [31:0] ctrl_r, rdata;
   pwt_count_t set_r [6], buf_r [6];
   pwt_count_t cnt_r, cap_rise_r, cap_fall_r, per_eff;
   logic [7:0] dly_r, ie_r, is_r, delay_set, is_set, is_clr, irq_mask;
   logic [4:0] sync_w, prev_r, rise_w;
   logic [3:0] idx;
   logic upd_r, pend_r, pend_trig_r, wr_en, rd_en, sw_start, sw_stop, cap_mode;
   logic tstart_ev, tstop_ev, tclr_ev, force_ev, running, start_req, stop_req;
   logic period_end, clear_ev, load_start, load_upd, load_src, load_all;
   logic cyc_stop_now, dly_done;

   ////////////////////////////////////////////////////////////////////////
   // Trigger pins: two flops, then rising edges taken from the second flop

   pwt_sync #(
      .W(5)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .async_in({capture_in, trig_force_in, trig_clear_in, trig_stop_in, trig_start_in}),
      .sync_out(sync_w)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r <= 5'h00;
      end else begin
         prev_r <= sync_w;
      end
   end

   assign rise_w = sync_w & ~prev_r;

   ////////////////////////////////////////////////////////////////////////
   // Event decode

   assign wr_en = psel & penable & pwrite & pready;
   assign rd_en = psel & penable & ~pwrite & pready;
   assign idx = pwt_reg_index(paddr);
   assign cap_mode = ctrl_r[`PWT_CTRL_CAP_MODE];
   assign delay_set = ctrl_r[`PWT_CTRL_DLY_MSB:`PWT_CTRL_DLY_LSB];
   assign sw_start = wr_en && idx == `PWT_IDX_CTRL && pwdata[`PWT_CTRL_START];
   assign sw_stop = wr_en && idx == `PWT_IDX_CTRL && pwdata[`PWT_CTRL_STOP];
   assign tstart_ev = ctrl_r[`PWT_CTRL_TSTART_EN] & rise_w[0];
   assign tstop_ev = ctrl_r[`PWT_CTRL_TSTOP_EN] & rise_w[1];
   assign tclr_ev = ctrl_r[`PWT_CTRL_TCLR_EN] & rise_w[2];
   assign force_ev = ctrl_r[`PWT_CTRL_FS_EN] & rise_w[3];
   assign running = state_r != PWT_ST_IDLE;
   // Starts are refused while the forced stop status stands
   assign start_req = (sw_start | tstart_ev) & ~is_r[`PWT_IS_FSTOP];
   assign stop_req = sw_stop | tstop_ev;
   assign per_eff = ctrl_r[`PWT_CTRL_SRC_SEL] ? buf_r[5] : buf_r[0];
   assign period_end = running && cnt_r >= per_eff;
   assign clear_ev = running & tclr_ev;
   assign cyc_stop_now = state_r == PWT_ST_RUN && pend_r && period_end && !start_req;
   assign dly_done = state_r == PWT_ST_DELAY && dly_r == 8'h01 && !start_req;

   // Buffer load sources
   assign load_start = state_r == PWT_ST_IDLE && start_req && !force_ev
      && cnt_r == 16'h0000;
   assign load_upd = (period_end | clear_ev) & upd_r;
   assign load_src = (period_end | clear_ev) & ctrl_r[`PWT_CTRL_SRC_SEL];
   assign load_all = load_start | load_upd | load_src;

   ////////////////////////////////////////////////////////////////////////
   // Run state and deferred stop

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= PWT_ST_IDLE;
         pend_r <= 1'b0;
         pend_trig_r <= 1'b0;
         dly_r <= 8'h00;
      end else begin
         case (state_r)
            PWT_ST_IDLE: begin
               if (start_req && !force_ev) begin
                  state_r <= PWT_ST_RUN;
               end
               pend_r <= 1'b0;
            end
            PWT_ST_RUN: begin
               if (force_ev) begin
                  state_r <= PWT_ST_IDLE;
                  pend_r <= 1'b0;
               end else if (start_req) begin
                  pend_r <= 1'b0;
               end else if (stop_req && !ctrl_r[`PWT_CTRL_CYC_EN]) begin
                  state_r <= PWT_ST_IDLE;
               end else if (cyc_stop_now) begin
                  pend_r <= 1'b0;
                  if (delay_set == 8'h00) begin
                     state_r <= PWT_ST_IDLE;
                  end else begin
                     state_r <= PWT_ST_DELAY;
                     dly_r <= delay_set;
                  end
               end else if (stop_req) begin
                  // Stop held back until the period runs out
                  pend_r <= 1'b1;
                  pend_trig_r <= tstop_ev;
               end
            end
            PWT_ST_DELAY: begin
               if (force_ev) begin
                  state_r <= PWT_ST_IDLE;
               end else if (start_req) begin
                  state_r <= PWT_ST_RUN;
               end else if (dly_done) begin
                  state_r <= PWT_ST_IDLE;
               end else begin
                  dly_r <= dly_r - 8'h01;
               end
            end
            default: begin
               state_r <= PWT_ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter: an immediate stop holds the value, a cycle stop leaves zero

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 16'h0000;
      end else if (running && !force_ev && !(stop_req && !ctrl_r[`PWT_CTRL_CYC_EN]
                   && state_r == PWT_ST_RUN && !start_req) && !dly_done) begin
         if (period_end || clear_ev) begin
            cnt_r <= 16'h0000;
         end else begin
            cnt_r <= cnt_r + 16'h0001;
         end
      end else if (dly_done) begin
         cnt_r <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Setting registers and working buffers

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 6; i++) begin
            set_r[i] <= (i == 0 || i == 5) ? `PWT_SET_RST : `PWT_CMP_RST;
         end
      end else if (wr_en && idx >= `PWT_IDX_PERIOD && idx <= `PWT_IDX_CONV) begin
         set_r[3'(idx - `PWT_IDX_PERIOD)] <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 6; i++) begin
            buf_r[i] <= (i == 0 || i == 5) ? `PWT_SET_RST : `PWT_CMP_RST;
         end
      end else if (load_all) begin
         for (int i = 0; i < 6; i++) begin
            buf_r[i] <= set_r[i];
         end
      end
   end

   // Software setting wins over the hardware clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upd_r <= 1'b0;
      end else if (wr_en && idx == `PWT_IDX_CTRL && pwdata[`PWT_CTRL_UPD]) begin
         upd_r <= 1'b1;
      end else if (load_upd) begin
         upd_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `PWT_CTRL_RST;
         ie_r <= `PWT_IE_RST;
      end else if (wr_en && idx == `PWT_IDX_CTRL) begin
         ctrl_r <= {13'h0000, pwdata[18:8], 1'b0, pwdata[6:3], 3'h0};
      end else if (wr_en && idx == `PWT_IDX_IE) begin
         ie_r <= {1'b0, pwdata[6:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture of the counter on both edges of the capture pin

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_rise_r <= 16'h0000;
         cap_fall_r <= 16'h0000;
      end else if (cap_mode) begin
         if (rise_w[4]) begin
            cap_rise_r <= cnt_r;
         end
         if (prev_r[4] && !sync_w[4]) begin
            cap_fall_r <= cnt_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status: set wins over every clear

   always_comb begin
      is_set = 8'h00;
      is_set[`PWT_IS_PERIOD] = period_end;
      if (cap_mode) begin
         is_set[`PWT_IS_C0R] = rise_w[4];
         is_set[`PWT_IS_C0F] = prev_r[4] & ~sync_w[4];
      end else begin
         is_set[`PWT_IS_C0R] = running && cnt_r == buf_r[1];
         is_set[`PWT_IS_C0F] = running && cnt_r == buf_r[2];
         is_set[`PWT_IS_C1R] = running && cnt_r == buf_r[3];
         is_set[`PWT_IS_C1F] = running && cnt_r == buf_r[4];
      end
      is_set[`PWT_IS_TSTOP] = (tstop_ev && !ctrl_r[`PWT_CTRL_CYC_EN] && running)
         || (pend_trig_r && (dly_done || (cyc_stop_now && delay_set == 8'h00)));
      is_set[`PWT_IS_TSTART] = tstart_ev & ~is_r[`PWT_IS_FSTOP];
      is_set[`PWT_IS_FSTOP] = force_ev;
      is_clr = 8'h00;
      if (wr_en && idx == `PWT_IDX_ICLR) begin
         is_clr = pwdata[7:0];
      end
      if (rd_en && idx == `PWT_IDX_IS) begin
         is_clr = 8'hFF;
      end
      if (rd_en && cap_mode && idx == `PWT_IDX_C0R) begin
         is_clr[`PWT_IS_C0R] = 1'b1;
      end
      if (rd_en && cap_mode && idx == `PWT_IDX_C0F) begin
         is_clr[`PWT_IS_C0F] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         is_r <= 8'h00;
      end else begin
         is_r <= (is_r & ~is_clr) | is_set;
      end
   end

   // Forced stop has no enable of its own; the function enable stands in
   assign irq_mask = {ctrl_r[`PWT_CTRL_FS_EN], ie_r[6:0]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(is_r & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // PWM outputs: high from rise compare up to fall compare

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm0_out <= 1'b0;
         pwm1_out <= 1'b0;
      end else begin
         pwm0_out <= running && !cap_mode && cnt_r >= buf_r[1] && cnt_r < buf_r[2];
         pwm1_out <= running && !cap_mode && cnt_r >= buf_r[3] && cnt_r < buf_r[4];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state so that read data comes from a flop

   always_comb begin
      rdata = 32'h0000_0000;
      case (idx)
         `PWT_IDX_CTRL: rdata = {ctrl_r[31:3], upd_r, 2'h0};
         `PWT_IDX_STAT: rdata = {cnt_r, 13'h0000, pend_r, state_r == PWT_ST_DELAY, running};
         `PWT_IDX_PERIOD: rdata = {16'h0000, set_r[0]};
         `PWT_IDX_C0R: rdata = {16'h0000, cap_mode ? cap_rise_r : set_r[1]};
         `PWT_IDX_C0F: rdata = {16'h0000, cap_mode ? cap_fall_r : set_r[2]};
         `PWT_IDX_C1R: rdata = {16'h0000, set_r[3]};
         `PWT_IDX_C1F: rdata = {16'h0000, set_r[4]};
         `PWT_IDX_CONV: rdata = {16'h0000, set_r[5]};
         `PWT_IDX_IE: rdata = {24'h000000, ie_r};
         `PWT_IDX_IS: rdata = {24'h000000, is_r};
         default: rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= idx == `PWT_IDX_NONE;
         prdata <= pwrite ? 32'h0000_0000 : rdata;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule : pwt_timer

// ### tb/pwt_timer_props.sv
/* Port-level assertions for the pwt_timer channel.
   Assumes a single pclk domain and an APB master that holds requests until pready. */
`timescale 1ns/1ps
`include "pwt_params.svh"
module pwt_timer_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pwm0_out,
   input wire logic pwm1_out,
   input wire logic irq
);
   logic [31:0] ctrl_r;
   logic [7:0] ie_r;
   logic wr_ok;
   logic quiet;
   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of control and enable writes, so masking can be judged at the ports
   assign wr_ok = psel && penable && pready && pwrite && !pslverr;
   assign quiet = (ie_r == 8'h00) && !ctrl_r[6];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 32'h0;
         ie_r <= 8'h00;
      end else if (wr_ok && paddr == {2'b00, `PWT_IDX_CTRL, 2'b00}) begin
         ctrl_r <= pwdata;
      end else if (wr_ok && paddr == {2'b00, `PWT_IDX_IE, 2'b00}) begin
         ie_r <= pwdata[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence first_acc;
      psel && penable && !$past(penable);
   endsequence
   sequence answer;
      pready && psel && penable;
   endsequence
   ready_lat_a: assert property (first_acc |-> !pready ##1 answer)
      else $error("pready not one wait state after access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_pair_a: assert property (pslverr |-> answer)
      else $error("pslverr without pready");
   align_err_a: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
      else $error("misaligned access not refused");
   unmap_err_a: assert property (pready && paddr[7:2] > `PWT_IDX_LAST |-> pslverr)
      else $error("unmapped access not refused");
   map_ok_a: assert property (pready && paddr[1:0] == 2'b00 && paddr[7:2] <= `PWT_IDX_LAST
      |-> !pslverr) else $error("mapped access refused");
   wr_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("read data not zero on write");
   mask_irq_a: assert property ($past(quiet) && quiet |-> !irq)
      else $error("irq with every source disabled");
   cap_pwm_a: assert property ($past(ctrl_r[5]) |-> !pwm0_out && !pwm1_out)
      else $error("pwm active in capture mode");
endmodule : pwt_timer_props
bind pwt_timer pwt_timer_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .pwm0_out, .pwm1_out, .irq);

// ### tb/pwm_timer_buffered_update_bench.sv
/* Self-checking bench for pwt_timer: buffers, cycle stop, interrupts, capture.
   Assumes pwt_params.svh on the include path and the props checker bound. */
`timescale 1ns/1ps
`include "pwt_params.svh"
module pwm_timer_buffered_update_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pwm0_out, pwm1_out, irq, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0] tg;
   int n_errors, tests_run, k;
   pwt_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .trig_start_in(tg[0]), .trig_stop_in(tg[1]),
      .trig_clear_in(tg[2]), .trig_force_in(tg[3]), .capture_in(tg[4]),
      .pwm0_out, .pwm1_out, .irq);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task wr(input logic [3:0] i, input logic [31:0] d);
      xfer(1'b1, {2'b00, i, 2'b00}, d);
   endtask : wr
   task rdc(input logic [3:0] i, input logic [31:0] m, input logic [31:0] e);
      xfer(1'b0, {2'b00, i, 2'b00}, 32'h0);
      chk(rd & m, e);
   endtask : rdc
   // Pins stay high and low long enough for the two-flop synchroniser
   task trig(input int b);
      @(posedge pclk) tg[b] <= 1'b1;
      cyc(4);
      tg[b] <= 1'b0;
      cyc(4);
   endtask : trig
   task duty(input int e);
      k = 0;
      repeat (20) begin
         @(negedge pclk);
         if (pwm0_out === 1'b1) k++;
      end
      chk(k, e);
   endtask : duty
   ////////////////////////////////////////////////////////////////////////////////
   task t_regs;
      rdc(`PWT_IDX_CTRL, 32'hFFFFFFFF, 32'h0);
      rdc(`PWT_IDX_PERIOD, 32'hFFFF, 32'hFFFF);
      rdc(`PWT_IDX_C0F, 32'hFFFF, 32'h0);
      wr(`PWT_IDX_IE, 32'hFF);
      rdc(`PWT_IDX_IE, 32'hFF, 32'h7F);
      wr(`PWT_IDX_IE, 32'h0);
      xfer(1'b0, 8'h2C, 32'h0);
      chk(err, 32'h1);
      xfer(1'b0, 8'h01, 32'h0);
      chk(err, 32'h1);
      $display("registers done");
   endtask : t_regs
   task t_buf;
      wr(`PWT_IDX_PERIOD, 32'h9);
      wr(`PWT_IDX_C0F, 32'h3);
      wr(`PWT_IDX_CTRL, 32'h1);
      cyc(5);
      duty(6);
      wr(`PWT_IDX_C0F, 32'h7);
      cyc(25);
      duty(6);
      wr(`PWT_IDX_CTRL, 32'h4);
      cyc(25);
      rdc(`PWT_IDX_CTRL, 32'h4, 32'h0);
      duty(14);
      $display("buffer update done");
   endtask : t_buf
   task t_cstop;
      wr(`PWT_IDX_ICLR, 32'hFF);
      wr(`PWT_IDX_IE, 32'h20);
      for (int j = 0; j < 2; j++) begin
         wr(`PWT_IDX_CTRL, 32'h20008 | (j * 32'h2800));
         @(posedge pclk) tg[1] <= 1'b1;
         k = 0;
         while (irq !== 1'b1 && k < 100) begin
            @(posedge pclk);
            k++;
            if (k == 4) tg[1] <= 1'b0;
         end
         if (j == 0) chk(k < 20, 32'h1);
         else chk(k >= 40 && k < 70, 32'h1);
         rdc(`PWT_IDX_STAT, 32'hFFFF0001, 32'h0);
         wr(`PWT_IDX_ICLR, 32'hFF);
         wr(`PWT_IDX_CTRL, 32'h1);
      end
      wr(`PWT_IDX_CTRL, 32'h22808);
      trig(1);
      wr(`PWT_IDX_CTRL, 32'h22809);
      cyc(100);
      rdc(`PWT_IDX_STAT, 32'h1, 32'h1);
      chk(irq, 32'h0);
      $display("cycle stop done");
   endtask : t_cstop
   task t_clr;
      wr(`PWT_IDX_PERIOD, 32'hC7);
      wr(`PWT_IDX_CTRL, 32'h40004);
      cyc(20);
      wr(`PWT_IDX_C0F, 32'h32);
      wr(`PWT_IDX_CTRL, 32'h40004);
      rdc(`PWT_IDX_CTRL, 32'h4, 32'h4);
      trig(2);
      rdc(`PWT_IDX_CTRL, 32'h4, 32'h0);
      wr(`PWT_IDX_CTRL, 32'h2);
      wr(`PWT_IDX_C0F, 32'h5);
      wr(`PWT_IDX_CTRL, 32'h1);
      cyc(3);
      chk(pwm0_out, 32'h1);
      $display("trigger clear done");
   endtask : t_clr
   task t_src;
      wr(`PWT_IDX_CONV, 32'h4);
      wr(`PWT_IDX_C0F, 32'h2);
      wr(`PWT_IDX_CTRL, 32'h40010);
      trig(2);
      duty(8);
      wr(`PWT_IDX_C0F, 32'h3);
      cyc(10);
      duty(12);
      $display("period source done");
   endtask : t_src
   task t_irq;
      wr(`PWT_IDX_ICLR, 32'hFF);
      cyc(20);
      chk(irq, 32'h0);
      wr(`PWT_IDX_IE, 32'h1);
      cyc(10);
      chk(irq, 32'h1);
      wr(`PWT_IDX_CTRL, 32'h2);
      wr(`PWT_IDX_ICLR, 32'h1);
      cyc(3);
      chk(irq, 32'h0);
      wr(`PWT_IDX_IE, 32'h0);
      wr(`PWT_IDX_CTRL, 32'h41);
      trig(3);
      rdc(`PWT_IDX_STAT, 32'h1, 32'h0);
      chk(irq, 32'h1);
      wr(`PWT_IDX_CTRL, 32'h41);
      rdc(`PWT_IDX_STAT, 32'h1, 32'h0);
      wr(`PWT_IDX_ICLR, 32'h80);
      cyc(3);
      chk(irq, 32'h0);
      wr(`PWT_IDX_CTRL, 32'h41);
      rdc(`PWT_IDX_STAT, 32'h1, 32'h1);
      $display("interrupts done");
   endtask : t_irq
   task t_cap;
      wr(`PWT_IDX_CTRL, 32'h21);
      wr(`PWT_IDX_ICLR, 32'hFF);
      wr(`PWT_IDX_IE, 32'h2);
      trig(4);
      chk(irq, 32'h1);
      xfer(1'b0, {2'b00, `PWT_IDX_C0R, 2'b00}, 32'h0);
      cyc(3);
      chk(irq, 32'h0);
      $display("capture done");
   endtask : t_cap
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #100_000;
      n_errors++;
      $display("ERROR t=%0t watchdog expired", $time);
      complete_run;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      tg = 5'h00;
      n_errors = 0;
      tests_run = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_buf;
      t_cstop;
      t_clr;
      t_src;
      t_irq;
      t_cap;
      complete_run;
   end
endmodule : pwm_timer_buffered_update_bench
